// file: dv/stl_pos_loop.sv
// position loop model: actual position trails the command
// assumes the bench drives cmd_pos synchronously to clk
`timescale 1ns/10ps
module stl_pos_loop
(
  input wire logic clk,
  input wire logic signed [63:0] cmd_pos,
  output logic signed [63:0] actual_pos
);
  // one cycle of loop lag, like a sampled encoder
  always_ff @(posedge clk)
    actual_pos <= cmd_pos;
endmodule

// file: dv/test_software_travel_limit_compare.sv
// self-checking bench for the travel-limit checker
// assumes stl_pos_loop as the position source, 40 MHz clock
`timescale 1ns/10ps
module test_software_travel_limit_compare
  import stl_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic homed = 1'b0;
  logic hw_lo = 1'b0;
  logic hw_hi = 1'b0;
  stl_req_t req = '0;
  logic signed [63:0] cmd = '0;
  logic signed [63:0] pos;
  stl_rsp_t rsp;
  logic refused;
  logic stop_lo;
  logic stop_hi;
  logic [1:0] st;
  int errors = 0;
  int total_checks = 0;
  int off[5] = '{-101, -100, 0, 100, 101};
  // shadow copies of what the bench has written
  logic [7:0] en;
  logic signed [63:0] b0;
  logic signed [63:0] b1;

  always #12.5 clk = ~clk;

  stl_top stl_top_i (.clk(clk), .rst_n(rst_n), .req(req),
    .axis_homed(homed), .actual_pos(pos), .hw_limit_lo(hw_lo),
    .hw_limit_hi(hw_hi), .rsp(rsp), .wr_refused(refused),
    .travel_bound_status(st), .stop_lo(stop_lo), .stop_hi(stop_hi));
  stl_pos_loop stl_pos_loop_i (.clk(clk), .cmd_pos(cmd),
    .actual_pos(pos));

  task check(input string nm, input logic [63:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // refusal pulse is looked at in the one cycle it stands
  task wr(input logic [15:0] a, input logic [63:0] d, input logic r);
    @(posedge clk) req <= '{1'b0, 1'b1, a, d};
    @(posedge clk) req.wr <= 1'b0;
    #1 check("wr_refused", refused, {63'h0, r});
  endtask

  task rd(input logic [15:0] a, input logic [63:0] exp);
    @(posedge clk) req <= '{1'b1, 1'b0, a, 64'h0};
    @(posedge clk) req.rd <= 1'b0;
    #1 check("rsp_valid", rsp.valid, 64'h1);
    check("rsp_data", rsp.data, exp);
  endtask

  // hold position and homing steady long enough for the stop path
  task cmp(input logic signed [63:0] p, input logic h);
    logic s0;
    logic s1;
    logic sw;
    @(posedge clk)
    begin
      cmd <= p;
      homed <= h;
    end
    repeat (4) @(posedge clk);
    #1;
    sw = en == 8'h03 && b0 > b1;
    s0 = en[0] && h && (sw ? p >= b0 : p <= b0);
    s1 = en[1] && h && (sw ? p <= b1 : p >= b1);
    check("status", {62'h0, st}, {62'h0, s1, s0});
    check("stop_lo", stop_lo, hw_lo | (sw ? s1 : s0));
    check("stop_hi", stop_hi, hw_hi | (sw ? s0 : s1));
  endtask

  task wrap_up;
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(STL_ADDR_ENABLE, 64'h0);
    rd(STL_ADDR_BOUND0, 64'h0);
    rd(STL_ADDR_BOUND1, STL_BOUND1_RESET);
    rd(STL_ADDR_STATUS, 64'h0);
    wr(STL_ADDR_ENABLE, 64'h4, 1'b1);
    rd(STL_ADDR_ENABLE, 64'h0);
    wr(STL_ADDR_STATUS, 64'h3, 1'b1);
    rd(16'h0400, 64'h0);
    for (int s = 0; s < 2; s++)
    begin
      b0 = s ? 64'sh64 : -64'sh64;
      b1 = -b0;
      wr(STL_ADDR_BOUND0, b0, 1'b0);
      rd(STL_ADDR_BOUND0, b0);
      wr(STL_ADDR_BOUND1, b1, 1'b0);
      for (int e = 0; e < 4; e++)
      begin
        en = e[7:0];
        wr(STL_ADDR_ENABLE, {56'h0, en}, 1'b0);
        rd(STL_ADDR_ENABLE, {56'h0, en});
        foreach (off[i])
          cmp(64'(off[i]), 1'b1);
        cmp(b0, 1'b0);
        cmp(b1, 1'b0);
      end
    end
    // hardware limits must still stop the axis alongside software ones
    @(posedge clk)
    begin
      hw_lo <= 1'b1;
      hw_hi <= 1'b1;
    end
    cmp(64'h0, 1'b1);
    rd(STL_ADDR_STATUS, 64'h0);
    wrap_up;
  end

  // watchdog, well beyond the few hundred cycles the tests take
  initial
  begin
    #(25 * 4000);
    errors++;
    wrap_up;
  end
endmodule

// file: verilog/stl_compare.sv
// registered compare unit: bound roles and per-limit active flags
// assumes position and bounds are stable two's complement numbers
`timescale 1ns/10ps
module stl_compare
  import stl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] en_mode,
  input wire logic axis_homed,
  input wire logic signed [63:0] bound_zero,
  input wire logic signed [63:0] bound_one,
  input wire logic signed [63:0] actual_pos,
  output logic [1:0] active,
  output logic lower_hit,
  output logic upper_hit
);

  logic [1:0] next_active;
  logic next_lower_hit;
  logic next_upper_hit;
  logic swap;
  logic zero_is_upper;
  logic hit_zero;
  logic hit_one;

  // role choice, then each limit checked against its own role
  always_comb
  begin
    swap = (en_mode == STL_EN_BOTH) && (bound_zero > bound_one);
    zero_is_upper = swap;
    hit_zero = zero_is_upper ? (actual_pos >= bound_zero)
                             : (actual_pos <= bound_zero);
    hit_one = zero_is_upper ? (actual_pos <= bound_one)
                            : (actual_pos >= bound_one);
    // a non-homed axis has no trustworthy position, so no limit acts
    next_active[STL_BIT_LIM0] = axis_homed && en_mode[STL_BIT_LIM0]
                                && hit_zero;
    next_active[STL_BIT_LIM1] = axis_homed && en_mode[STL_BIT_LIM1]
                                && hit_one;
    next_lower_hit = zero_is_upper ? next_active[STL_BIT_LIM1]
                                   : next_active[STL_BIT_LIM0];
    next_upper_hit = zero_is_upper ? next_active[STL_BIT_LIM0]
                                   : next_active[STL_BIT_LIM1];
  end

  // flags registered once per clock
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      active <= 2'b00;
      lower_hit <= 1'b0;
      upper_hit <= 1'b0;
    end
    else
    begin
      active <= next_active;
      lower_hit <= next_lower_hit;
      upper_hit <= next_upper_hit;
    end
  end

endmodule

// file: verilog/stl_pkg.sv
// shared constants and carrier types for the software travel-limit checker
// assumes a single 40 MHz clock and a parameter port owned by the drive logic
package stl_pkg;

  // parameter addresses on the drive's parameter port
  localparam logic [15:0] STL_ADDR_ENABLE = 16'h02fc;
  localparam logic [15:0] STL_ADDR_BOUND0 = 16'h02fe;
  localparam logic [15:0] STL_ADDR_BOUND1 = 16'h0302;
  localparam logic [15:0] STL_ADDR_STATUS = 16'h0306;

  // widths and reset values
  localparam int STL_EN_W = 8;
  localparam int STL_POS_W = 64;
  localparam logic [7:0] STL_EN_RESET = 8'h00;
  localparam logic [7:0] STL_EN_MAX = 8'h03;
  localparam logic [63:0] STL_BOUND0_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] STL_BOUND1_RESET = 64'h0000_0000_0010_0000;

  // field positions of the enable setting and of the status word
  localparam int STL_BIT_LIM0 = 0;
  localparam int STL_BIT_LIM1 = 1;

  // enable setting encodings
  typedef enum logic [1:0]
  {
    STL_EN_NONE = 2'b00,
    STL_EN_ZERO = 2'b01,
    STL_EN_ONE = 2'b10,
    STL_EN_BOTH = 2'b11
  } stl_en_mode_t;

  // one access on the parameter port
  typedef struct packed
  {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [63:0] wdata;
  } stl_req_t;

  // answer to a read
  typedef struct packed
  {
    logic valid;
    logic [63:0] data;
  } stl_rsp_t;

endpackage

// file: verilog/stl_top.sv
// software travel-limit checker: parameters, compare unit, stop outputs
// assumes req fields are synchronous to clk and rd and wr never overlap
//
// Function
// - enable 0 none, 1 only limit 0, 2 only limit 1, 3 both
// - enable bit 0 gates limit 0, bit 1 gates limit 1
// - no limit is active until the axis has been homed
// - with both enabled the greater bound is the upper bound
// - otherwise limit 0 is lower bound and limit 1 upper bound
// - enable held as 8-bit unsigned, 0 to 3, reset 0
// - limit 0 is a signed 64-bit position, reset to zero
// - limit 0 is the compare operand, lower or upper by configuration
// - software limits add to hardware limit inputs, never replace them
// - status reports each limit compared against actual position
// - status bit 0 limit 0 active, bit 1 limit 1, rest zero
`timescale 1ns/10ps
module stl_top
  import stl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire stl_req_t req,
  input wire logic axis_homed,
  input wire logic signed [63:0] actual_pos,
  input wire logic hw_limit_lo,
  input wire logic hw_limit_hi,
  output stl_rsp_t rsp,
  output logic wr_refused,
  output logic [1:0] travel_bound_status,
  output logic stop_lo,
  output logic stop_hi
);

  logic [7:0] travel_limit_enable_cfg;
  logic signed [63:0] travel_bound_zero;
  logic signed [63:0] travel_bound_one;
  logic [7:0] next_enable;
  logic [63:0] next_bound_zero;
  logic [63:0] next_bound_one;
  stl_rsp_t next_rsp;
  logic next_refused;
  logic lower_hit;
  logic upper_hit;
  logic next_stop_lo;
  logic next_stop_hi;

  // true for a write to one address
  function automatic logic wr_to(input stl_req_t r, input logic [15:0] a);
    wr_to = r.wr && (r.addr == a);
  endfunction

  // true for a read of one address
  function automatic logic rd_at(input stl_req_t r, input logic [15:0] a);
    rd_at = r.rd && (r.addr == a);
  endfunction

  // parameter writes; an out-of-range enable is dropped whole, not clipped
  always_comb
  begin
    next_enable = travel_limit_enable_cfg;
    next_bound_zero = travel_bound_zero;
    next_bound_one = travel_bound_one;
    next_refused = 1'b0;
    if (wr_to(req, STL_ADDR_ENABLE))
    begin
      if (req.wdata[63:0] <= {56'h0, STL_EN_MAX})
        next_enable = req.wdata[7:0];
      else
        next_refused = 1'b1;
    end
    else if (wr_to(req, STL_ADDR_BOUND0))
      next_bound_zero = req.wdata;
    else if (wr_to(req, STL_ADDR_BOUND1))
      next_bound_one = req.wdata;
    else if (wr_to(req, STL_ADDR_STATUS))
      next_refused = 1'b1; // status is read-only
  end

  // read answers one cycle after the request; unmapped reads give zero
  always_comb
  begin
    next_rsp.valid = req.rd;
    next_rsp.data = 64'h0000_0000_0000_0000;
    if (rd_at(req, STL_ADDR_ENABLE))
      next_rsp.data = {56'h0, travel_limit_enable_cfg};
    else if (rd_at(req, STL_ADDR_BOUND0))
      next_rsp.data = travel_bound_zero;
    else if (rd_at(req, STL_ADDR_BOUND1))
      next_rsp.data = travel_bound_one;
    else if (rd_at(req, STL_ADDR_STATUS))
      next_rsp.data = {62'h0, travel_bound_status};
  end

  // hardware inputs are ORed with the software limits, then registered one clock
  always_comb
  begin
    next_stop_lo = hw_limit_lo || lower_hit;
    next_stop_hi = hw_limit_hi || upper_hit;
  end

  // parameter and answer registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      travel_limit_enable_cfg <= STL_EN_RESET;
      travel_bound_zero <= STL_BOUND0_RESET;
      travel_bound_one <= STL_BOUND1_RESET;
      rsp <= '0;
      wr_refused <= 1'b0;
      stop_lo <= 1'b0;
      stop_hi <= 1'b0;
    end
    else
    begin
      travel_limit_enable_cfg <= next_enable;
      travel_bound_zero <= next_bound_zero;
      travel_bound_one <= next_bound_one;
      rsp <= next_rsp;
      wr_refused <= next_refused;
      stop_lo <= next_stop_lo;
      stop_hi <= next_stop_hi;
    end
  end

  // compare unit; its flags are the status word itself
  stl_compare stl_compare_i
  (
    .clk(clk),
    .rst_n(rst_n),
    .en_mode(travel_limit_enable_cfg[1:0]),
    .axis_homed(axis_homed),
    .bound_zero(travel_bound_zero),
    .bound_one(travel_bound_one),
    .actual_pos(actual_pos),
    .active(travel_bound_status),
    .lower_hit(lower_hit),
    .upper_hit(upper_hit)
  );

  // checks on the decoded behaviour, one clock of compare latency
  AST_OFF_WHEN_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    travel_limit_enable_cfg == 8'h00 |=> travel_bound_status == 2'b00)
    else $error("limit active with enable 0");
  AST_ONLY_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    travel_limit_enable_cfg == 8'h01 |=> !travel_bound_status[1])
    else $error("limit 1 active with enable 1");
  AST_ONLY_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    travel_limit_enable_cfg == 8'h02 |=> !travel_bound_status[0])
    else $error("limit 0 active with enable 2");
  AST_NOT_HOMED: assert property (@(posedge clk) disable iff (!rst_n)
    !axis_homed |=> travel_bound_status == 2'b00)
    else $error("limit active on unhomed axis");
  AST_BOTH_SWAP: assert property (@(posedge clk) disable iff (!rst_n)
    travel_limit_enable_cfg == 8'h03 && axis_homed
    && travel_bound_zero > travel_bound_one
    && actual_pos >= travel_bound_zero
    |=> travel_bound_status[0] ##1 stop_hi)
    else $error("greater bound not used as upper");
  AST_SINGLE_LOWER: assert property (@(posedge clk) disable iff (!rst_n)
    travel_limit_enable_cfg == 8'h01 && axis_homed
    && actual_pos <= travel_bound_zero |=> travel_bound_status[0])
    else $error("limit 0 not acting as lower bound");
  AST_UPPER_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    travel_limit_enable_cfg == 8'h02 && axis_homed
    && actual_pos >= travel_bound_one |=> travel_bound_status[1])
    else $error("limit 1 not acting as upper bound");
  AST_EN_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
    travel_limit_enable_cfg <= 8'h03)
    else $error("enable outside 0 to 3");
  AST_BOUND0_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && req.addr == STL_ADDR_BOUND0
    |=> travel_bound_zero == $past(req.wdata))
    else $error("limit 0 write not stored");
  AST_HW_PASS: assert property (@(posedge clk) disable iff (!rst_n)
    hw_limit_lo |=> stop_lo)
    else $error("hardware limit masked");
  AST_HW_PASS_HI: assert property (@(posedge clk) disable iff (!rst_n)
    hw_limit_hi |=> stop_hi)
    else $error("hardware upper limit masked");
  // the stop pair lags the status word by one more clock
  AST_BOTH_LOWER: assert property (@(posedge clk) disable iff (!rst_n)
    travel_limit_enable_cfg == 8'h03 && axis_homed
    && travel_bound_zero > travel_bound_one && actual_pos <= travel_bound_one
    |=> travel_bound_status[1] ##1 stop_lo)
    else $error("smaller bound not used as lower");
  AST_BOTH_PLAIN: assert property (@(posedge clk) disable iff (!rst_n)
    travel_limit_enable_cfg == 8'h03 && axis_homed
    && travel_bound_zero <= travel_bound_one && actual_pos <= travel_bound_zero
    |=> travel_bound_status[0] ##1 stop_lo)
    else $error("smaller limit 0 not used as lower");
  // enable writes: in range stored, out of range refused and kept
  AST_EN_STORE: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && req.addr == STL_ADDR_ENABLE
    && req.wdata <= 64'h0000_0000_0000_0003
    |=> {56'h0, travel_limit_enable_cfg} == $past(req.wdata))
    else $error("enable write not stored");
  AST_EN_REFUSE: assert property (@(posedge clk) disable iff (!rst_n)
    req.wr && req.addr == STL_ADDR_ENABLE
    && req.wdata > 64'h0000_0000_0000_0003
    |=> wr_refused && $stable(travel_limit_enable_cfg))
    else $error("out-of-range enable not refused");
  AST_EN_READ: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && req.addr == STL_ADDR_ENABLE
    |=> rsp.valid && rsp.data == {56'h0, $past(travel_limit_enable_cfg)})
    else $error("enable read mismatch");
  AST_STATUS_READ: assert property (@(posedge clk) disable iff (!rst_n)
    req.rd && req.addr == STL_ADDR_STATUS
    |=> rsp.valid && rsp.data == {62'h0, $past(travel_bound_status)})
    else $error("status read mismatch");

  // main scenarios, watched by coverage; swap, lower stop and refusal are also asserted above
  COV_BOTH_SWAPPED: cover property (@(posedge clk) disable iff (!rst_n)
    travel_limit_enable_cfg == 8'h03 && travel_bound_zero > travel_bound_one
    && travel_bound_status[0]);
  COV_LOWER_STOP: cover property (@(posedge clk) disable iff (!rst_n)
    stop_lo && !hw_limit_lo);
  COV_REFUSED: cover property (@(posedge clk) disable iff (!rst_n)
    wr_refused);
  COV_BOTH_PLAIN: cover property (@(posedge clk) disable iff (!rst_n)
    travel_limit_enable_cfg == 8'h03 && travel_bound_zero < travel_bound_one
    && travel_bound_status[1]);

endmodule
